// File: acpi_wake_power_control_tb.sv
// Self-checking bench for the power and wake controller.
// Assumes apwc_pkg, apwc_map.svh and the far-side model are compiled first.
`timescale 1ns/100ps
`include "apwc_map.svh"
`define APWC_CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module acpi_wake_power_control_tb;
    import apwc_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic         clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
    logic         restore_en, prior_on, dual_color, cpu_hot, vr_hot, main_rail;
    logic         psu_on, fan_en, live_on, stby_led, green, amber, cpu_ind, vr_ind;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rdat;
    logic [6:0]   wake_cmd, wake_line;
    logic [1:0]   btn_cmd, btn_n, fan_tach, fan_pwm;
    apwc_pstate_e sleep_state;
    int           n_fail = 0, total_checks = 0, cyc = 0;
    logic [2:0]   codes [4] = '{3'h1, 3'h3, 3'h4, 3'h5};

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Short counts keep button holds and fan windows within a few hundred cycles
    apwc_top #(.DEB_CYC(4), .LONG_CYC(40), .OB_CYC(30), .WIN_CYC(64)) u_dut (
        .SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .LAN_WAKE(wake_line[0]), .RING(wake_line[1]), .USB_WAKE(wake_line[2]),
        .PS2_WAKE(wake_line[3]), .PME_N(wake_line[4]), .PCIE_WAKE_N(wake_line[5]),
        .RTC_ALARM(wake_line[6]), .FP_BTN_N(btn_n[0]), .OB_BTN_N(btn_n[1]),
        .FAN_TACH(fan_tach), .RESTORE_EN(restore_en), .PRIOR_ON(prior_on),
        .DUAL_COLOR(dual_color), .CPU_HOT(cpu_hot), .VR_HOT(vr_hot),
        .SLEEP_STATE(sleep_state), .PSU_ON(psu_on), .FAN_EN(fan_en), .FAN_PWM(fan_pwm),
        .LIVE_ON(live_on), .STBY_LED(stby_led), .PANEL_GREEN(green), .PANEL_AMBER(amber),
        .PROCESSOR_HEAT_INDICATOR(cpu_ind), .REGULATOR_HEAT_INDICATOR(vr_ind));

    apwc_far_model u_far (
        .clk(clk), .rst(rst), .psu_on(psu_on), .fan_en(fan_en), .fan_pwm(fan_pwm),
        .wake_cmd(wake_cmd), .btn_cmd(btn_cmd), .wake_line(wake_line), .btn_n(btn_n),
        .fan_tach(fan_tach), .main_rail(main_rail));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // One APB transfer; read data and error are taken at the completing edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic press(input int b, input int n);
        @(posedge clk);
        btn_cmd <= 2'h1 << b;
        tick(n);
        btn_cmd <= 2'h0;
        tick(14);
    endtask : press

    function automatic apwc_pstate_e state_of(input logic [2:0] c);
        case (c)
            3'h1: return ST_S1;
            3'h3: return ST_S3;
            3'h4: return ST_S4;
            default: return ST_S5;
        endcase
    endfunction : state_of

    // en: b0 PME enable, b1 S5 network/PME enable, b2 modem interrupt unmasked
    function automatic logic wakes(input int s, input logic [2:0] c, input logic [2:0] en);
        logic shallow;
        shallow = (c == 3'h1) || (c == 3'h3);
        case (s)
            0: return shallow || c == 3'h4 || en[1];
            1: return shallow && en[2];
            2, 3: return shallow;
            4: return en[0] && (c != 3'h5 || en[1]);
            default: return 1'b1;
        endcase
    endfunction : wakes

    task automatic wake_case(input int s, input logic [2:0] c, input logic [2:0] en);
        apwc_pstate_e exp_st;
        dual_color <= en[0];
        apb(1'b1, `APWC_CTRL_OFF, {26'h0, 3'h3, en});
        apb(1'b1, `APWC_SLEEP_OFF, {29'h0, c});
        // A second sleep command outside S0 must be ignored
        apb(1'b1, `APWC_SLEEP_OFF, 32'h5);
        tick(2);
        `APWC_CHK(sleep_state, state_of(c))
        `APWC_CHK(fan_en, c == 3'h1)
        `APWC_CHK({fan_pwm[1], fan_pwm[0] && c != 3'h1}, 2'h0)
        `APWC_CHK(main_rail, c == 3'h1)
        `APWC_CHK(amber, c == 3'h3 && en[0])
        wake_cmd <= 7'h1 << s;
        tick(6);
        exp_st = wakes(s, c, en) ? ST_S0 : state_of(c);
        `APWC_CHK(sleep_state, exp_st)
        `APWC_CHK(live_on, exp_st == ST_S0 || exp_st == ST_S1)
        wake_cmd <= 7'h0;
        tick(4);
        if (sleep_state !== ST_S0) begin
            press(0, 10);
        end
    endtask : wake_case

    task automatic final_report;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Timeout and main sequence
    // ----------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; restore_en = 1'b1; prior_on = 1'b0; dual_color = 1'b1;
        cpu_hot = 1'b0; vr_hot = 1'b0; wake_cmd = 7'h0; btn_cmd = 2'h0;
        for (int i = 0; i < 3; i++) begin
            restore_en <= (i != 1);
            prior_on <= (i != 0);
            rst <= 1'b1;
            tick(10);
            rst <= 1'b0;
            tick(3);
            `APWC_CHK(sleep_state, (i == 2) ? ST_S0 : ST_S5)
            `APWC_CHK(fan_en, i == 2)
            `APWC_CHK(stby_led, 1'b1)
        end
        $display("test reset and restore done");
        apb(1'b0, `APWC_CTRL_OFF, 32'h0);
        `APWC_CHK(rdat, 32'h18)
        apb(1'b0, 8'h40, 32'h0);
        `APWC_CHK({rerr, rdat}, {1'b1, 32'h0})
        `APWC_CHK(pready, 1'b1)
        cpu_hot <= 1'b1;
        tick(3);
        `APWC_CHK({cpu_ind, vr_ind}, 2'h2)
        cpu_hot <= 1'b0;
        vr_hot <= 1'b1;
        tick(3);
        `APWC_CHK({cpu_ind, vr_ind}, 2'h1)
        vr_hot <= 1'b0;
        $display("test registers and indicators done");
        press(0, 10);
        `APWC_CHK({sleep_state, green}, {ST_S3, 1'b0})
        press(0, 10);
        `APWC_CHK(sleep_state, ST_S0)
        press(0, 60);
        `APWC_CHK(sleep_state, ST_S5)
        press(1, 10);
        `APWC_CHK(sleep_state, ST_S0)
        press(1, 40);
        `APWC_CHK(sleep_state, ST_S5)
        press(0, 10);
        `APWC_CHK(sleep_state, ST_S0)
        $display("test buttons done");
        apb(1'b1, `APWC_FTGT_OFF, 32'h8);
        tick(64 * 12);
        apb(1'b0, `APWC_FSTAT_OFF, 32'h0);
        `APWC_CHK(rdat[23:16] != 8'h00, 1'b1)
        `APWC_CHK(rdat[31:24], 8'h00)
        $display("test fan loop done");
        for (int e = 0; e < 2; e++) begin
            for (int s = 0; s < 7; s++) begin
                for (int k = 0; k < 4; k++) begin
                    wake_case(s, codes[k], (e == 1) ? 3'h7 : 3'h0);
                end
            end
        end
        // Every source has woken the system once, so all cause bits are latched
        apb(1'b0, `APWC_STAT_OFF, 32'h0);
        `APWC_CHK(rdat, 32'h0000FF06)
        apb(1'b1, `APWC_STAT_OFF, 32'h0000FF00);
        apb(1'b0, `APWC_STAT_OFF, 32'h0);
        `APWC_CHK(rdat, 32'h00000006)
        $display("test wake table done");
        final_report();
    end
endmodule : acpi_wake_power_control_tb

// File: apwc_far_model.sv
// Far-side model: power supply rails, wake sources, buttons and fan tachometers.
// Assumes the bench raises one command bit per wake source and per button.
`timescale 1ns/100ps
module apwc_far_model (
    input  wire logic       clk,       // Standby clock
    input  wire logic       rst,       // Reset, high
    input  wire logic       psu_on,    // Main supply request
    input  wire logic       fan_en,    // Fan supply enable
    input  wire logic [1:0] fan_pwm,   // Fan drive
    input  wire logic [6:0] wake_cmd,  // LAN,ring,USB,PS2,PME,PCIe,RTC event
    input  wire logic [1:0] btn_cmd,   // Front, onboard pressed
    output logic      [6:0] wake_line, // Wake pins, PME and PCIe low active
    output logic      [1:0] btn_n,     // Buttons, pulled up when released
    output logic      [1:0] fan_tach,  // Tach pulses
    output logic            main_rail  // Non-standby rails up
);
    // ----------------------------------------
    // Supply, wake sources, buttons
    // ----------------------------------------
    // Only the standby rail survives a sleep command to S3, S4 or S5; in S1 the main rails stay up
    assign main_rail = psu_on;
    // A wake frame seen on the network raises the LAN wake line
    assign wake_line = wake_cmd ^ 7'h30;
    assign btn_n     = ~btn_cmd;
    // ----------------------------------------
    // Fans
    // ----------------------------------------
    // An unpowered or undriven fan gives no pulses, so the loop must raise duty itself
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fan_tach <= 2'h0;
        end else begin
            fan_tach <= {2{fan_en}} & fan_pwm & ~fan_tach;
        end
    end
endmodule : apwc_far_model

// File: apwc_map.svh
// Offsets, field positions, reset values and timing figures of the power controller.
// Assumes a 32-bit APB slave with byte addresses in the low eight bits.
`ifndef APWC_MAP_SVH
`define APWC_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define APWC_CTRL_OFF   8'h00
`define APWC_SLEEP_OFF  8'h04
`define APWC_STAT_OFF   8'h08
`define APWC_FTGT_OFF   8'h0C
`define APWC_FSTAT_OFF  8'h10
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define APWC_CTRL_PME   0
`define APWC_CTRL_S5    1
`define APWC_CTRL_RING  2
`define APWC_CTRL_BSLP  3
`define APWC_CTRL_RST   6'h18
`define APWC_STAT_CAUSE 8
// ----------------------------------------
// Synchroniser slots
// ----------------------------------------
`define APWC_I_LAN   0
`define APWC_I_RING  1
`define APWC_I_USB   2
`define APWC_I_PS2   3
`define APWC_I_PME   4
`define APWC_I_PCIW  5
`define APWC_I_RTC   6
`define APWC_I_BTN   7
`define APWC_I_TACH  9
// ----------------------------------------
// Timing
// ----------------------------------------
`define APWC_CLK_HZ     25000000
`define APWC_DEB_MS     10
`define APWC_FP_LONG_S  4
`define APWC_OB_HOLD_S  3
`define APWC_FAN_WIN_MS 100
`endif

// File: apwc_pkg.sv
// Types of the power and wake controller.
// Assumes the widths of the default timing figures.
package apwc_pkg;
    typedef enum logic [4:0] {
        ST_S0 = 5'h01,
        ST_S1 = 5'h02,
        ST_S3 = 5'h04,
        ST_S4 = 5'h08,
        ST_S5 = 5'h10
    } apwc_pstate_e;

    typedef struct packed {
        apwc_pstate_e     st;
        logic             boot;
        logic [10:0]      s1;
        logic [10:0]      s2;
        logic [1:0]       btn;
        logic [1:0][17:0] deb;
        logic [1:0][26:0] hold;
        logic             pme_en;
        logic             s5_en;
        logic             ring_en;
        logic [2:0]       btn_slp;
        logic [7:0]       cause;
        logic [1:0]       tprev;
        logic [1:0][7:0]  tgt;
        logic [1:0][7:0]  duty;
        logic [1:0][7:0]  meas;
        logic [1:0][7:0]  tcnt;
        logic [21:0]      win;
        logic [7:0]       pwm;
        logic [1:0]       fan_pwm;
        logic             fan_en;
        logic             psu_on;
        logic             green;
        logic             amber;
        logic             cpu_heat;
        logic             vr_heat;
        logic [31:0]      rdata;
    } apwc_state_s;
endpackage : apwc_pkg

// File: apwc_top.sv
// Sleep-state tracker, wake combiner, button timer, fan loop and indicators.
// Assumes standby power and SYS_CLK run whenever AC is present; RST marks AC return.
`timescale 1ns/100ps
`include "apwc_map.svh"
module apwc_top
    import apwc_pkg::*;
#(
    parameter int unsigned DEB_CYC  = `APWC_CLK_HZ / 1000 * `APWC_DEB_MS,
    parameter int unsigned LONG_CYC = `APWC_CLK_HZ * `APWC_FP_LONG_S,
    parameter int unsigned OB_CYC   = `APWC_CLK_HZ * `APWC_OB_HOLD_S,
    parameter int unsigned WIN_CYC  = `APWC_CLK_HZ / 1000 * `APWC_FAN_WIN_MS
) (
    input  wire logic        SYS_CLK,        // Standby clock
    input  wire logic        RST,            // Async reset, high
    input  wire logic        PSEL,           // APB select
    input  wire logic        PENABLE,        // APB access phase
    input  wire logic        PWRITE,         // APB write
    input  wire logic [7:0]  PADDR,          // APB byte address
    input  wire logic [31:0] PWDATA,         // APB write data
    output logic      [31:0] PRDATA,         // APB read data
    output logic             PREADY,         // APB ready
    output logic             PSLVERR,        // APB error, unmapped
    input  wire logic        LAN_WAKE,       // Network wake request
    input  wire logic        RING,           // Modem ring
    input  wire logic        USB_WAKE,       // USB activity
    input  wire logic        PS2_WAKE,       // PS/2 activity
    input  wire logic        PME_N,          // PCI PME, low
    input  wire logic        PCIE_WAKE_N,    // PCIe wake, low
    input  wire logic        RTC_ALARM,      // RTC alarm
    input  wire logic        FP_BTN_N,       // Front button, low
    input  wire logic        OB_BTN_N,       // Onboard button, low
    input  wire logic [1:0]  FAN_TACH,       // Tach pulses
    input  wire logic        RESTORE_EN,     // Restore after AC loss
    input  wire logic        PRIOR_ON,       // Saved state was on
    input  wire logic        DUAL_COLOR,     // Panel LED dual colour
    input  wire logic        CPU_HOT,        // Processor over-temp
    input  wire logic        VR_HOT,         // Regulator over-temp
    output apwc_pkg::apwc_pstate_e SLEEP_STATE, // Current state
    output logic             PSU_ON,         // Main supply enable
    output logic             FAN_EN,         // Fan supply enable
    output logic      [1:0]  FAN_PWM,        // Fan drive
    output logic             LIVE_ON,        // State to save, on
    output logic             STBY_LED,       // Standby indicator
    output logic             PANEL_GREEN,    // Panel LED green
    output logic             PANEL_AMBER,    // Panel LED amber
    output logic             PROCESSOR_HEAT_INDICATOR, // Processor hot
    output logic             REGULATOR_HEAT_INDICATOR  // Regulator hot
);
    import apwc_pkg::*;

    localparam logic [17:0] DEB_M1 = 18'(DEB_CYC - 1);
    localparam logic [21:0] WIN_M1 = 22'(WIN_CYC - 1);
    localparam logic [1:0][26:0] LIM = {27'(OB_CYC), 27'(LONG_CYC)};

    apwc_state_s q;
    apwc_state_s n;
    logic [10:0] raw;
    logic [7:0]  wk;
    logic [1:0]  rel;
    logic [1:0]  shrt;
    logic [1:0]  lng;
    logic        light;
    logic        slp;
    logic        s5ok;
    logic        wr;
    logic        hit;
    logic        slp_go;
    logic        force_off;
    apwc_pstate_e cmd_st;

    function automatic apwc_pstate_e code_st(input logic [2:0] c);
        case (c)
            3'h1:    code_st = ST_S1;
            3'h4:    code_st = ST_S4;
            3'h5:    code_st = ST_S5;
            default: code_st = ST_S3;
        endcase
    endfunction : code_st

    // ----------------------------------------
    // Input conditioning
    // ----------------------------------------
    // Active-low lines are inverted ahead of the synchroniser so every slot is active high
    assign raw = {FAN_TACH, ~OB_BTN_N, ~FP_BTN_N, RTC_ALARM, ~PCIE_WAKE_N, ~PME_N,
                  PS2_WAKE, USB_WAKE, RING, LAN_WAKE};

    assign hit = PADDR == `APWC_CTRL_OFF || PADDR == `APWC_SLEEP_OFF ||
                 PADDR == `APWC_STAT_OFF || PADDR == `APWC_FTGT_OFF ||
                 PADDR == `APWC_FSTAT_OFF;
    assign wr = PSEL && PENABLE && PWRITE;

    always_comb begin
        n = q;
        n.s1 = raw;
        n.s2 = q.s1;
        n.boot = 1'b0;
        // ----------------------------------------
        // Debounce and press timing
        // ----------------------------------------
        for (int i = 0; i < 2; i++) begin
            if (q.s2[`APWC_I_BTN + i] == q.btn[i]) begin
                n.deb[i] = '0;
            end else if (q.deb[i] >= DEB_M1) begin
                n.btn[i] = q.s2[`APWC_I_BTN + i];
                n.deb[i] = '0;
            end else begin
                n.deb[i] = q.deb[i] + 18'h1;
            end
            n.hold[i] = !q.btn[i] ? 27'h0 :
                        (&q.hold[i]) ? q.hold[i] : q.hold[i] + 27'h1;
            rel[i] = q.btn[i] && !n.btn[i];
            shrt[i] = rel[i] && q.hold[i] < LIM[i];
            lng[i] = q.btn[i] && q.hold[i] == LIM[i] - 27'h1;
        end
        force_off = |lng;
        // ----------------------------------------
        // Wake combination
        // ----------------------------------------
        light = q.st == ST_S1 || q.st == ST_S3;
        slp = light || q.st == ST_S4 || q.st == ST_S5;
        s5ok = q.st != ST_S5 || q.s5_en;
        wk[0] = q.s2[`APWC_I_LAN] && slp && s5ok;
        wk[1] = q.s2[`APWC_I_RING] && light && q.ring_en;
        wk[2] = q.s2[`APWC_I_USB] && light;
        wk[3] = q.s2[`APWC_I_PS2] && light;
        wk[4] = q.s2[`APWC_I_PME] && q.pme_en && slp && s5ok;
        wk[5] = q.s2[`APWC_I_PCIW] && slp;
        wk[6] = q.s2[`APWC_I_RTC] && slp;
        wk[7] = |shrt && slp;
        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        cmd_st = code_st(PWDATA[2:0]);
        slp_go = wr && PADDR == `APWC_SLEEP_OFF && q.st == ST_S0 &&
                 (PWDATA[2:0] == 3'h1 || PWDATA[2:0] == 3'h3 ||
                  PWDATA[2:0] == 3'h4 || PWDATA[2:0] == 3'h5);
        if (wr && PADDR == `APWC_CTRL_OFF) begin
            n.pme_en = PWDATA[`APWC_CTRL_PME];
            n.s5_en = PWDATA[`APWC_CTRL_S5];
            n.ring_en = PWDATA[`APWC_CTRL_RING];
            n.btn_slp = PWDATA[`APWC_CTRL_BSLP +: 3];
        end
        if (wr && PADDR == `APWC_FTGT_OFF) begin
            n.tgt = PWDATA[15:0];
        end
        // Write-one-to-clear, but a wake in the same cycle stays latched
        n.cause = q.cause & ~((wr && PADDR == `APWC_STAT_OFF) ?
                  PWDATA[`APWC_STAT_CAUSE +: 8] : 8'h00);
        n.cause = n.cause | wk;
        // ----------------------------------------
        // Power state
        // ----------------------------------------
        if (q.boot) begin
            n.st = (RESTORE_EN && PRIOR_ON) ? ST_S0 : ST_S5;
        end else if (force_off) begin
            n.st = ST_S5;
        end else if (|wk) begin
            n.st = ST_S0;
        end else if (q.st == ST_S0 && |shrt) begin
            n.st = code_st(q.btn_slp);
        end else if (slp_go) begin
            n.st = cmd_st;
        end
        // ----------------------------------------
        // Fan loop
        // ----------------------------------------
        n.pwm = q.pwm + 8'h1;
        n.win = (q.win >= WIN_M1) ? 22'h0 : q.win + 22'h1;
        n.tprev = q.s2[`APWC_I_TACH +: 2];
        n.fan_en = n.st == ST_S0 || n.st == ST_S1;
        for (int i = 0; i < 2; i++) begin
            if (q.win >= WIN_M1) begin
                n.meas[i] = q.tcnt[i];
                n.tcnt[i] = 8'h00;
                if (q.tcnt[i] < q.tgt[i] && q.duty[i] != 8'hFF) begin
                    n.duty[i] = q.duty[i] + 8'h1;
                end else if (q.tcnt[i] > q.tgt[i] && q.duty[i] != 8'h00) begin
                    n.duty[i] = q.duty[i] - 8'h1;
                end
            end else if (q.s2[`APWC_I_TACH + i] && !q.tprev[i] && q.tcnt[i] != 8'hFF) begin
                n.tcnt[i] = q.tcnt[i] + 8'h1;
            end
            n.fan_pwm[i] = n.fan_en && q.tgt[i] != 8'h00 &&
                           q.pwm < n.duty[i];
        end
        // ----------------------------------------
        // Supply and indicators
        // ----------------------------------------
        n.psu_on = n.st == ST_S0 || n.st == ST_S1;
        n.green = n.psu_on;
        n.amber = n.st == ST_S3 && DUAL_COLOR;
        n.cpu_heat = CPU_HOT;
        n.vr_heat = VR_HOT;
        // ----------------------------------------
        // Read data, captured in the setup cycle
        // ----------------------------------------
        n.rdata = 32'h0;
        if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
                `APWC_CTRL_OFF:  n.rdata = {26'h0, q.btn_slp, q.ring_en, q.s5_en, q.pme_en};
                `APWC_SLEEP_OFF: n.rdata = {27'h0, q.st};
                `APWC_STAT_OFF:  n.rdata = {16'h0, q.cause, 3'h0, q.btn, q.psu_on,
                                            q.fan_en, q.boot};
                `APWC_FTGT_OFF:  n.rdata = {16'h0, q.tgt};
                `APWC_FSTAT_OFF: n.rdata = {q.duty, q.meas};
                default:         n.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            q <= '{st: ST_S5, boot: 1'b1, btn_slp: 3'h3, default: '0};
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign PRDATA = q.rdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit;
    assign SLEEP_STATE = q.st;
    assign PSU_ON = q.psu_on;
    assign FAN_EN = q.fan_en;
    assign FAN_PWM = q.fan_pwm;
    assign LIVE_ON = q.psu_on;
    assign STBY_LED = 1'b1;
    assign PANEL_GREEN = q.green;
    assign PANEL_AMBER = q.amber;
    assign PROCESSOR_HEAT_INDICATOR = q.cpu_heat;
    assign REGULATOR_HEAT_INDICATOR = q.vr_heat;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    fan_on_a: assert property ((q.st == ST_S0 || q.st == ST_S1) |-> FAN_EN)
        else $error("fans off in a working state");
    fan_off_a: assert property (!(q.st == ST_S0 || q.st == ST_S1) |->
        !FAN_EN && FAN_PWM == 2'b00) else $error("fans driven while asleep");
    ring_mask_a: assert property (!q.ring_en && slp && q.s2[6:0] == 7'h02 &&
        !(|shrt) && !force_off && !q.boot |=> $stable(q.st))
        else $error("masked ring woke");
    deep_wake_a: assert property ((q.st == ST_S4 || q.st == ST_S5) &&
        (q.s2[6:0] & 7'h71) == 7'h00 && !(|shrt) && !force_off && !q.boot
        |=> $stable(q.st)) else $error("light-only wake from deep state");
    pme_s5_a: assert property (q.st == ST_S5 && !q.s5_en &&
        (q.s2[6:0] & 7'h6E) == 7'h00 && !(|shrt) && !force_off && !q.boot
        |=> q.st == ST_S5) else $error("net or PME wake from S5 while off");
    pme_en_a: assert property (!q.pme_en && slp && q.s2[6:0] == 7'h10 &&
        !(|shrt) && !force_off && !q.boot |=> $stable(q.st))
        else $error("PME wake while disabled");
    s3_dark_a: assert property (q.st == ST_S3 && $past(q.st) == ST_S3 |->
        !PSU_ON && !PANEL_GREEN && PANEL_AMBER == $past(DUAL_COLOR))
        else $error("S3 supply or panel wrong");
    wake_up_a: assert property (slp && |wk && !force_off && !q.boot
        |=> q.st == ST_S0) else $error("wake did not reach S0");
    awake_hold_a: assert property (q.st == ST_S0 && !slp_go && !(|shrt) &&
        !force_off && !q.boot |=> q.st == ST_S0) else $error("S0 left without cause");
    long_off_a: assert property (force_off && !q.boot |=> q.st == ST_S5)
        else $error("long press did not power off");
    heat_led_a: assert property (##1 PROCESSOR_HEAT_INDICATOR == $past(CPU_HOT) &&
        REGULATOR_HEAT_INDICATOR == $past(VR_HOT)) else $error("heat indicator stale");
endmodule : apwc_top
